// ### core/tdio_cfg.svh
// constants of the transmitter digital io control block
`ifndef TDIO_CFG_SVH
`define TDIO_CFG_SVH

// ==========================================================
// clocking and timing
`define TDIO_CLK_HZ        25000000
`define TDIO_TICK_S        1
`define TDIO_SEC_CYCLES    (`TDIO_TICK_S * `TDIO_CLK_HZ)
`define TDIO_CYCLES_MIN    4'h1
`define TDIO_CYCLES_MAX    4'ha

// ==========================================================
// register byte offsets
`define TDIO_OFS_CTRL      12'h000
`define TDIO_OFS_LINK      12'h004
`define TDIO_OFS_TIMING    12'h008
`define TDIO_OFS_STATUS    12'h00c
`define TDIO_OFS_INT_STAT  12'h010
`define TDIO_OFS_INT_EN    12'h014
`define TDIO_OFS_INT_CLR   12'h018

// ==========================================================
// field positions and reset values
`define TDIO_CTRL_TRIG_LSB 0
`define TDIO_LINK_CYC_LSB  0
`define TDIO_LINK_LLVL_BIT 4
`define TDIO_LINK_RC_LSB   5
`define TDIO_TIM_PER_LSB   0
`define TDIO_TIM_WARM_LSB  16
`define TDIO_CTRL_RST      32'h0000_0000
`define TDIO_LINK_RST      32'h0000_0011
`define TDIO_TIMING_RST    32'h0000_003c
`define TDIO_NUM_EVENTS    4
`define TDIO_EV_TRIG       0
`define TDIO_EV_LOST       1
`define TDIO_EV_RESTORE    2
`define TDIO_EV_COMM       3

`endif

// ### core/tdio_pkg.sv
// types of the transmitter digital io control block
package tdio_pkg;
   // input trigger setting
   typedef enum logic [1:0] {TRIG_DIS, TRIG_RISE, TRIG_FALL, TRIG_BOTH} tdio_trig_t;
   // startup state of an output
   typedef enum logic [1:0] {START_OFF, START_ON, START_LAST} tdio_start_t;
   // remote-control output on link loss
   typedef enum logic [1:0] {RCL_OFF, RCL_ON, RCL_HOLD} tdio_rclost_t;
endpackage : tdio_pkg

// ### core/tdio_edge_det.sv
// digital input synchroniser and trigger edge detector
`timescale 1ns/1ps
`default_nettype none
module tdio_edge_det (
   // clock and reset
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               clk_en,
   // pin and setting
   input  wire logic               din_pin,
   input  wire tdio_pkg::tdio_trig_t mode,
   // results
   output logic                    din_level,
   output logic                    trig
);
   logic sync1_reg;
   logic sync2_reg;
   logic prev_reg;

   // two flops before anything reads the pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         prev_reg  <= 1'b0;
      end else if (clk_en) begin
         sync1_reg <= din_pin;
         sync2_reg <= sync1_reg;
         prev_reg  <= sync2_reg;
      end
   end

   // edge select per trigger setting
   always_comb begin
      trig = 1'b0;
      unique case (mode)
         tdio_pkg::TRIG_DIS:  trig = 1'b0;
         tdio_pkg::TRIG_RISE: trig = sync2_reg & ~prev_reg;
         tdio_pkg::TRIG_FALL: trig = ~sync2_reg & prev_reg;
         tdio_pkg::TRIG_BOTH: trig = sync2_reg ^ prev_reg;
      endcase
   end
   assign din_level = sync2_reg;

   a_disabled_quiet: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == tdio_pkg::TRIG_DIS) |-> !trig) else $error("trigger while disabled");
endmodule : tdio_edge_det
`default_nettype wire

// ### core/tdio_warmup.sv
// communication period scheduler with external power warm-up
`timescale 1ns/1ps
`default_nettype none
module tdio_warmup (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        clk_en,
   // timing
   input  wire logic        sec_tick,
   input  wire logic [15:0] period,
   input  wire logic [7:0]  warmup,
   // results
   output logic             comm_due,
   output logic             pwr_on,
   output logic             warm_start
);
   logic [15:0] remain_reg;
   logic        pwr_prev_reg;

   // seconds left until the next scheduled communication
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         remain_reg   <= 16'h0001;
         pwr_prev_reg <= 1'b0;
      end else if (clk_en) begin
         pwr_prev_reg <= pwr_on;
         if (sec_tick) begin
            remain_reg <= (remain_reg <= 16'h0001) ? period : remain_reg - 16'h0001;
         end
      end
   end
   assign comm_due = sec_tick && (remain_reg <= 16'h0001);

   // power on within warm-up seconds; always on if too long
   assign pwr_on = ({8'h00, warmup} > period) || (remain_reg <= {8'h00, warmup});
   // leave sleep as the warm-up starts
   assign warm_start = pwr_on && !pwr_prev_reg;

   a_warm_forever: assert property (@(posedge pclk) disable iff (!presetn)
      ({8'h00, warmup} > period) |-> pwr_on) else $error("power dropped with long warm-up");
endmodule : tdio_warmup
`default_nettype wire

// ### core/tdio_top.sv
// top of the transmitter digital io control block
`timescale 1ns/1ps
`default_nettype none
`include "tdio_cfg.svh"
module tdio_top #(
   parameter int unsigned SEC_CYCLES = `TDIO_SEC_CYCLES
) (
   // clock, reset, enable
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        clk_en,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // digital input pin
   input  wire logic        din_pin,
   // radio side, same clock
   input  wire logic        link_ok,
   input  wire logic        rc_cmd_valid,
   input  wire logic        rc_cmd,
   // retained startup settings and last states
   input  wire logic [1:0]  ll_start,
   input  wire logic [1:0]  rc_start,
   input  wire logic        ll_last,
   input  wire logic        rc_last,
   // outputs
   output logic             comm_req,
   output logic             link_lost_out,
   output logic             rc_out,
   output logic             ext_pwr,
   output logic             sleep_exit,
   output logic             irq
);
   // ==========================================================
   // register state
   logic [31:0] ctrl_reg;
   logic [31:0] link_reg;
   logic [31:0] timing_reg;
   logic [`TDIO_NUM_EVENTS-1:0] int_stat_reg;
   logic [`TDIO_NUM_EVENTS-1:0] int_en_reg;
   logic [31:0] prdata_reg;
   logic        pready_reg;
   logic        pslverr_reg;
   logic [31:0] rd_next;
   logic        rd_hit;
   logic        wr_en;
   logic        setup;

   // ==========================================================
   // block state
   logic [24:0] presc_reg;
   logic        sec_tick;
   logic [3:0]  miss_reg;
   logic        lost_reg;
   logic        init_reg;
   logic        comm_req_reg;
   logic        ll_out_reg;
   logic        rc_out_reg;
   logic        pwr_reg;
   logic        sleep_exit_reg;
   logic        irq_reg;
   logic        trig;
   logic        din_level;
   logic        comm_due;
   logic        pwr_on;
   logic        warm_start;
   logic [3:0]  cycles;
   logic        lost_now;
   logic        lost_rise;
   logic        restore;
   logic [`TDIO_NUM_EVENTS-1:0] events;
   tdio_pkg::tdio_trig_t   trig_mode;
   tdio_pkg::tdio_rclost_t rc_lost_mode;

   assign trig_mode    = tdio_pkg::tdio_trig_t'(ctrl_reg[`TDIO_CTRL_TRIG_LSB +: 2]);
   assign rc_lost_mode = tdio_pkg::tdio_rclost_t'(link_reg[`TDIO_LINK_RC_LSB +: 2]);

   // ==========================================================
   // apb slave
   assign setup = psel && !penable;
   assign wr_en = psel && penable && pready_reg && pwrite && !pslverr_reg;

   // read mux, also flags unmapped addresses
   always_comb begin
      rd_next = 32'h0000_0000;
      rd_hit  = 1'b1;
      unique case (paddr)
         `TDIO_OFS_CTRL:     rd_next = ctrl_reg;
         `TDIO_OFS_LINK:     rd_next = link_reg;
         `TDIO_OFS_TIMING:   rd_next = timing_reg;
         `TDIO_OFS_STATUS:   rd_next = {20'h00000, miss_reg, 1'b0, din_level, sleep_exit_reg,
                                        pwr_reg, rc_out_reg, ll_out_reg, init_reg, lost_reg};
         `TDIO_OFS_INT_STAT: rd_next = {28'h0000000, int_stat_reg};
         `TDIO_OFS_INT_EN:   rd_next = {28'h0000000, int_en_reg};
         `TDIO_OFS_INT_CLR:  rd_next = 32'h0000_0000;
         default:            rd_hit  = 1'b0;
      endcase
   end

   // one wait-free access phase: answer prepared during setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
      end else if (clk_en) begin
         pready_reg  <= setup;
         pslverr_reg <= setup && !rd_hit;
         if (setup && !pwrite) begin
            prdata_reg <= rd_next;
         end
      end
   end

   // configuration registers written at the completing edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg   <= `TDIO_CTRL_RST;
         link_reg   <= `TDIO_LINK_RST;
         timing_reg <= `TDIO_TIMING_RST;
         int_en_reg <= 4'h0;
      end else if (clk_en && wr_en) begin
         unique case (paddr)
            `TDIO_OFS_CTRL:   ctrl_reg   <= {30'h00000000, pwdata[1:0]};
            `TDIO_OFS_LINK:   link_reg   <= {25'h0000000, pwdata[6:0]};
            `TDIO_OFS_TIMING: timing_reg <= {8'h00, pwdata[23:0]};
            `TDIO_OFS_INT_EN: int_en_reg <= pwdata[`TDIO_NUM_EVENTS-1:0];
            default:          ;
         endcase
      end
   end

   // ==========================================================
   // interrupts: sticky status, a set wins over a clear
   assign events = {comm_req_reg, restore, lost_rise, trig};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_stat_reg <= 4'h0;
         irq_reg      <= 1'b0;
      end else if (clk_en) begin
         if (wr_en && paddr == `TDIO_OFS_INT_CLR) begin
            int_stat_reg <= (int_stat_reg & ~pwdata[`TDIO_NUM_EVENTS-1:0]) | events;
         end else begin
            int_stat_reg <= int_stat_reg | events;
         end
         irq_reg <= |(int_stat_reg & int_en_reg);
      end
   end

   // ==========================================================
   // one-second tick; the count is a parameter so a bench can shorten it
   assign sec_tick = (presc_reg == 25'(SEC_CYCLES - 1));
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         presc_reg <= 25'h0000000;
      end else if (clk_en) begin
         presc_reg <= sec_tick ? 25'h0000000 : presc_reg + 25'h0000001;
      end
   end

   // ==========================================================
   // submodules
   tdio_edge_det u_edge (
      .pclk      (pclk),
      .presetn   (presetn),
      .clk_en    (clk_en),
      .din_pin   (din_pin),
      .mode      (trig_mode),
      .din_level (din_level),
      .trig      (trig)
   );

   tdio_warmup u_warm (
      .pclk       (pclk),
      .presetn    (presetn),
      .clk_en     (clk_en),
      .sec_tick   (sec_tick),
      .period     (timing_reg[`TDIO_TIM_PER_LSB +: 16]),
      .warmup     (timing_reg[`TDIO_TIM_WARM_LSB +: 8]),
      .comm_due   (comm_due),
      .pwr_on     (pwr_on),
      .warm_start (warm_start)
   );

   // ==========================================================
   // communication request: scheduled or input triggered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         comm_req_reg <= 1'b0;
      end else if (clk_en) begin
         comm_req_reg <= comm_due || trig;
      end
   end

   // ==========================================================
   // link supervision; threshold clamped so a stray code stays in range
   assign cycles = (link_reg[`TDIO_LINK_CYC_LSB +: 4] < `TDIO_CYCLES_MIN) ? `TDIO_CYCLES_MIN :
                   (link_reg[`TDIO_LINK_CYC_LSB +: 4] > `TDIO_CYCLES_MAX) ? `TDIO_CYCLES_MAX :
                   link_reg[`TDIO_LINK_CYC_LSB +: 4];
   assign lost_now  = (miss_reg >= cycles);
   assign lost_rise = lost_now && !lost_reg;
   assign restore   = link_ok && lost_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         miss_reg <= 4'h0;
         lost_reg <= 1'b0;
      end else if (clk_en) begin
         if (link_ok) begin
            miss_reg <= 4'h0;
            lost_reg <= 1'b0;
         end else begin
            // saturate so a long outage cannot wrap back to "linked"
            if (comm_due && miss_reg != 4'hf) begin
               miss_reg <= miss_reg + 4'h1;
            end
            // loss declared at the configured count
            lost_reg <= lost_now;
         end
      end
   end

   // ==========================================================
   // startup capture happens on the first enabled edge after release
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         init_reg <= 1'b1;
      end else if (clk_en) begin
         init_reg <= 1'b0;
      end
   end

   // link-lost indicator output
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ll_out_reg <= 1'b0;
      end else if (clk_en) begin
         if (init_reg) begin
            unique case (ll_start)
               2'h0:    ll_out_reg <= 1'b0;
               2'h1:    ll_out_reg <= 1'b1;
               default: ll_out_reg <= ll_last;
            endcase
         end else if (lost_rise) begin
            ll_out_reg <= link_reg[`TDIO_LINK_LLVL_BIT];
         end else if (restore) begin
            ll_out_reg <= !link_reg[`TDIO_LINK_LLVL_BIT];
         end
      end
   end

   // remote-control output
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rc_out_reg <= 1'b0;
      end else if (clk_en) begin
         if (init_reg) begin
            unique case (rc_start)
               2'h0:    rc_out_reg <= 1'b0;
               2'h1:    rc_out_reg <= 1'b1;
               default: rc_out_reg <= rc_last;
            endcase
         end else if (link_ok && rc_cmd_valid) begin
            rc_out_reg <= rc_cmd;
         end else if (lost_rise) begin
            // on, off or hold on loss
            unique case (rc_lost_mode)
               tdio_pkg::RCL_OFF: rc_out_reg <= 1'b0;
               tdio_pkg::RCL_ON:  rc_out_reg <= 1'b1;
               default:           rc_out_reg <= rc_out_reg;
            endcase
         end
      end
   end

   // external power and wake, registered to keep outputs on flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwr_reg        <= 1'b0;
         sleep_exit_reg <= 1'b0;
      end else if (clk_en) begin
         pwr_reg        <= pwr_on;
         sleep_exit_reg <= warm_start;
      end
   end

   // ==========================================================
   // outputs
   assign prdata        = prdata_reg;
   assign pready        = pready_reg;
   assign pslverr       = pslverr_reg;
   assign comm_req      = comm_req_reg;
   assign link_lost_out = ll_out_reg;
   assign rc_out        = rc_out_reg;
   assign ext_pwr       = pwr_reg;
   assign sleep_exit    = sleep_exit_reg;
   assign irq           = irq_reg;

   // ==========================================================
   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_edge_seen;
      clk_en && trig;
   endsequence
   sequence s_req_out;
      comm_req;
   endsequence

   // trigger yields a request next cycle
   a_trig_request: assert property (s_edge_seen |=> s_req_out)
      else $error("input edge did not request communication");
   // falling mode never fires on a rising input
   a_fall_only: assert property (clk_en && trig && trig_mode == tdio_pkg::TRIG_FALL
      |-> !din_level) else $error("falling trigger on high input");
   // both mode fires on each change
   a_both_change: assert property (clk_en && trig_mode == tdio_pkg::TRIG_BOTH
      && $changed(din_level) |-> trig) else $error("missed level change");
   a_lost_thresh: assert property (clk_en && !link_ok && miss_reg >= cycles && !init_reg
      |=> lost_reg) else $error("loss not declared at threshold");
   a_success_clr: assert property (clk_en && link_ok |=> miss_reg == 4'h0 && !lost_reg)
      else $error("successful exchange did not clear loss");
   a_lost_level: assert property (clk_en && lost_rise && !init_reg
      |=> ll_out_reg == $past(link_reg[`TDIO_LINK_LLVL_BIT])) else $error("wrong lost level");
   a_rc_follow: assert property (clk_en && !init_reg && link_ok && rc_cmd_valid
      |=> rc_out == $past(rc_cmd)) else $error("remote output ignored command");
   a_pwr_track: assert property (clk_en |=> ext_pwr == $past(pwr_on))
      else $error("external power not following warm-up");
   // wake pulse only at power rise
   a_wake_rise: assert property (sleep_exit && $past(clk_en)
      |-> ext_pwr && $past(warm_start)) else $error("wake without warm-up start");
   a_start_off: assert property (clk_en && init_reg && ll_start == 2'h0
      |=> !link_lost_out) else $error("startup off not applied");
endmodule : tdio_top
`default_nettype wire

// ### verif/tdio_field_model.sv
// field wire and gateway model driving the block's far-side inputs
`timescale 1ns/1ps
`default_nettype none
module tdio_field_model (
   // clock
   input  wire logic pclk,
   // field wire and gateway exchange pulses
   output logic      din_pin,
   output logic      link_ok,
   output logic      rc_cmd_valid,
   output logic      rc_cmd
);
   // ==========================================
   // idle levels at time zero
   initial begin
      din_pin = 1'b0;
      link_ok = 1'b0;
      rc_cmd_valid = 1'b0;
      rc_cmd = 1'b0;
   end
   // field wire changes just after an edge
   task automatic set_din(input logic v);
      @(posedge pclk);
      din_pin <= v;
   endtask : set_din
   // exchange after dly + 1 rising edges; rc_cmd flips afterwards so a stale level is never seen
   task automatic exchange(input logic cmd, input int dly);
      repeat (dly + 1) @(posedge pclk);
      link_ok <= 1'b1;
      rc_cmd_valid <= 1'b1;
      rc_cmd <= cmd;
      @(posedge pclk);
      link_ok <= 1'b0;
      rc_cmd_valid <= 1'b0;
      rc_cmd <= ~cmd;
   endtask : exchange
endmodule : tdio_field_model
`default_nettype wire

// ### verif/testbench.sv
// self-checking testbench of the digital io control block
`timescale 1ns/1ps
`default_nettype none
`include "tdio_cfg.svh"
module testbench;
   localparam int SEC = 20;
   logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic din_pin, link_ok, rc_cmd_valid, rc_cmd, ll_last, rc_last, last_err;
   logic [1:0] ll_start, rc_start;
   logic comm_req, link_lost_out, rc_out, ext_pwr, sleep_exit, irq;
   int bad_count, check_count, comm_cnt, cyc;
   // ==========================================
   // clock, counters and timeout
   initial pclk = 1'b0;
   always #20 pclk = ~pclk;
   // pulses are counted at the falling edge where they are settled
   always @(negedge pclk) if (comm_req === 1'b1) comm_cnt++;
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 30000) begin
         bad_count++;
         give_verdict();
      end
   end
   tdio_field_model fm (.pclk(pclk), .din_pin(din_pin), .link_ok(link_ok),
      .rc_cmd_valid(rc_cmd_valid), .rc_cmd(rc_cmd));
   tdio_top #(.SEC_CYCLES(SEC)) dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .din_pin(din_pin),
      .link_ok(link_ok), .rc_cmd_valid(rc_cmd_valid), .rc_cmd(rc_cmd),
      .ll_start(ll_start), .rc_start(rc_start), .ll_last(ll_last), .rc_last(rc_last),
      .comm_req(comm_req), .link_lost_out(link_lost_out), .rc_out(rc_out),
      .ext_pwr(ext_pwr), .sleep_exit(sleep_exit), .irq(irq));
   // ==========================================
   // shared tasks
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // apb transfer: request held until pready is high at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // completion edge: pready sampled high while the request still stands
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      q = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wait_hi(ref logic s, input int lim);
      int n;
      n = 0;
      @(negedge pclk);
      while (s !== 1'b1 && n < lim) begin
         @(negedge pclk);
         n++;
      end
   endtask : wait_hi
   task automatic do_reset(input logic [1:0] ls, input logic [1:0] rs, input logic ll,
                           input logic rl);
      @(posedge pclk);
      presetn <= 1'b0;
      ll_start <= ls;
      rc_start <= rs;
      ll_last <= ll;
      rc_last <= rl;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
   endtask : do_reset
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : give_verdict
   // ==========================================
   // scenarios
   task automatic t_start();
      logic [7:0] tb [4];
      // {ll_start, rc_start, ll_last, rc_last, expected ll, expected rc}
      tb = '{8'h46, 8'hba, 8'h1d, 8'he5};
      foreach (tb[i]) begin
         do_reset(tb[i][7:6], tb[i][5:4], tb[i][3], tb[i][2]);
         @(negedge pclk);
         chk("ll_startup", {31'h0, tb[i][1]}, {31'h0, link_lost_out});
         chk("rc_startup", {31'h0, tb[i][0]}, {31'h0, rc_out});
      end
      $display("test startup done");
   endtask : t_start
   task automatic t_regs();
      apb(1'b0, `TDIO_OFS_CTRL, 32'h0);
      chk("ctrl_rst", `TDIO_CTRL_RST, q);
      apb(1'b0, `TDIO_OFS_LINK, 32'h0);
      chk("link_rst", `TDIO_LINK_RST, q);
      apb(1'b0, `TDIO_OFS_TIMING, 32'h0);
      chk("timing_rst", `TDIO_TIMING_RST, q);
      apb(1'b0, 12'h01c, 32'h0);
      chk("unmapped_err", 32'h1, {31'h0, last_err});
      $display("test registers done");
   endtask : t_regs
   task automatic t_trig();
      int n0;
      apb(1'b1, `TDIO_OFS_TIMING, 32'h0000_ffff);
      // let the pending scheduled request pass before counting
      repeat (SEC + 2) @(posedge pclk);
      for (int m = 0; m < 4; m++) begin
         apb(1'b1, `TDIO_OFS_CTRL, 32'(m));
         n0 = comm_cnt;
         fm.set_din(1'b1);
         repeat (10) @(posedge pclk);
         chk("rise_comm", 32'(m % 2), 32'(comm_cnt - n0));
         n0 = comm_cnt;
         fm.set_din(1'b0);
         repeat (10) @(posedge pclk);
         chk("fall_comm", 32'(m / 2), 32'(comm_cnt - n0));
      end
      // clock enable low freezes the synchroniser; the edge shows after thaw
      n0 = comm_cnt;
      clk_en <= 1'b0;
      fm.set_din(1'b1);
      repeat (10) @(posedge pclk);
      chk("frozen_comm", 32'h0, 32'(comm_cnt - n0));
      clk_en <= 1'b1;
      repeat (10) @(posedge pclk);
      chk("thaw_comm", 32'h1, 32'(comm_cnt - n0));
      // interrupt raised masked, then enabled, then cleared
      apb(1'b1, `TDIO_OFS_INT_EN, 32'h0);
      apb(1'b1, `TDIO_OFS_INT_CLR, 32'hf);
      fm.set_din(1'b0);
      repeat (10) @(posedge pclk);
      apb(1'b0, `TDIO_OFS_INT_STAT, 32'h0);
      chk("int_trig", 32'h1, q & 32'h1);
      chk("irq_masked", 32'h0, {31'h0, irq});
      apb(1'b1, `TDIO_OFS_INT_EN, 32'h1);
      repeat (2) @(negedge pclk);
      chk("irq_on", 32'h1, {31'h0, irq});
      apb(1'b1, `TDIO_OFS_INT_CLR, 32'h1);
      apb(1'b0, `TDIO_OFS_INT_STAT, 32'h0);
      chk("int_clr", 32'h0, q & 32'h1);
      chk("irq_off", 32'h0, {31'h0, irq});
      $display("test trigger done");
   endtask : t_trig
   task automatic t_link();
      do_reset(2'h0, 2'h0, 1'b0, 1'b0);
      apb(1'b1, `TDIO_OFS_TIMING, 32'h0000_0002);
      apb(1'b1, `TDIO_OFS_LINK, 32'h0000_0033);
      fm.exchange(1'b0, 0);
      wait_hi(link_lost_out, 600);
      apb(1'b0, `TDIO_OFS_STATUS, 32'h0);
      chk("miss_at_loss", 32'h3, (q >> 8) & 32'hf);
      chk("lost_flag", 32'h1, q & 32'h1);
      chk("ll_level", 32'h1, {31'h0, link_lost_out});
      chk("rc_on_loss", 32'h1, {31'h0, rc_out});
      fm.exchange(1'b0, 3);
      repeat (4) @(negedge pclk);
      chk("ll_restored", 32'h0, {31'h0, link_lost_out});
      chk("rc_follow0", 32'h0, {31'h0, rc_out});
      apb(1'b0, `TDIO_OFS_STATUS, 32'h0);
      chk("miss_cleared", 32'h0, q & 32'hf01);
      apb(1'b0, `TDIO_OFS_INT_STAT, 32'h0);
      chk("int_loss_restore", 32'h6, q & 32'h6);
      fm.exchange(1'b1, 0);
      repeat (4) @(negedge pclk);
      chk("rc_follow1", 32'h1, {31'h0, rc_out});
      $display("test link done");
   endtask : t_link
   task automatic t_warm();
      int gap, lows;
      gap = 0;
      lows = 0;
      apb(1'b1, `TDIO_OFS_TIMING, 32'h0002_0004);
      wait_hi(comm_req, 200);
      wait_hi(sleep_exit, 200);
      chk("wake_seen", 32'h1, {31'h0, sleep_exit});
      chk("wake_pwr", 32'h1, {31'h0, ext_pwr});
      while (comm_req !== 1'b1 && gap < 200) begin
         @(negedge pclk);
         gap++;
         lows += (ext_pwr !== 1'b1);
      end
      chk("warm_lead", 32'h1, {31'h0, gap >= 2 * SEC - 1 && gap <= 2 * SEC + 1});
      chk("pwr_held", 32'h0, 32'(lows));
      apb(1'b1, `TDIO_OFS_TIMING, 32'h0005_0004);
      wait_hi(comm_req, 200);
      lows = 0;
      repeat (200) begin
         @(negedge pclk);
         lows += (ext_pwr !== 1'b1);
      end
      chk("pwr_always", 32'h0, 32'(lows));
      $display("test warm-up done");
   endtask : t_warm
   // ==========================================
   // main sequence
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, ll_last, rc_last} = '0;
      {ll_start, rc_start} = '0;
      clk_en = 1'b1;
      {bad_count, check_count, comm_cnt, cyc} = '0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_start();
      t_regs();
      t_trig();
      t_link();
      t_warm();
      give_verdict();
   end
endmodule : testbench
`default_nettype wire
